// [core/fpcs_pkg.sv]
// Package for the four-phase core switch fabric: timing, phases and pulse bundle
package fpcs_pkg;
    // Clock rate and pulse widths
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned TRANSFER_NS    = 1000;
    localparam int unsigned READ_NS        = 2000;
    // Transfer width rounds down (longest time), at least one cycle
    localparam int unsigned TRANSFER_CYC   = (TRANSFER_NS / CLK_PERIOD_NS) < 1 ? 1 : (TRANSFER_NS / CLK_PERIOD_NS);
    localparam int unsigned READ_CYC       = 2 * TRANSFER_CYC;
    localparam int unsigned CNT_W          = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_LAST  = 8'(TRANSFER_CYC - 1);
    localparam int unsigned NUM_PHASES     = 4;
    localparam int unsigned NUM_CELLS      = 4;

    typedef enum logic [1:0] {
        FPCS_PH0,
        FPCS_PH1,
        FPCS_PH2,
        FPCS_PH3
    } fpcs_phase_e;

    typedef struct packed {
        logic [3:0] transfer;
        logic [3:0] read;
    } fpcs_pulses_s;
endpackage

// [core/fpcs_cell.sv]
// One magnetic switch storage cell: one bit with set, clear and read inputs
`timescale 1ns/1ps
`default_nettype none
module fpcs_cell (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic set_in,
    input  wire logic clear_in,
    input  wire logic read_in,
    input  wire logic read_first,
    output logic      bit_out,
    output logic      stored
);
    logic bit_r;
    logic bit_nxt;
    logic out_r;
    logic out_nxt;

    // Read start empties the cell; clear after set wins (inhibit) [RULE1] [RULE9] [RULE13]
    assign bit_nxt = read_first ? 1'b0 :
                     clear_in   ? 1'b0 :
                     set_in     ? 1'b1 : bit_r;
    // Output latched at read start, held through the read pulse [RULE2]
    assign out_nxt = read_first ? bit_r : (read_in ? out_r : 1'b0);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bit_r <= 1'b0; // [RULE14]
            out_r <= 1'b0;
        end else begin
            bit_r <= bit_nxt;
            out_r <= out_nxt;
        end
    end

    assign bit_out = out_r;
    assign stored  = bit_r;
endmodule
`default_nettype wire

// [core/fpcs_core.sv]
// Four-phase pulse distributor driving a ring of core switch cells
// Operation
// RULE1: Each cell stores one bit with set, clear and read inputs.
// RULE2: Set or clear is remembered until read presents the bit onward.
// RULE3: Pulses reach all cells together in a repeating phase 0..3 cycle.
// RULE4: No two transfer pulse phases are ever active together.
// RULE5: Consecutive read pulses overlap by one microsecond.
// RULE6: Transfer lasts 1 us, read 2 us, read outlasts transfer by 1 us.
// RULE7: Transfer starts with its read pulse and fills its first half.
// RULE8: Reading a 1 with transfer sets destination and clears source.
// RULE9: Reading a 0 leaves destination 0 and source 0; reads destroy.
// RULE10: Destination holds 0 before transfer; transfer only sets.
// RULE11: Cell read at phase n accepts inputs only at n-2 and n-1.
// RULE12: No set or clear during phase n or n+1 of its read.
// RULE13: Inhibit: set one phase before clear, clear forces 0 before read.
// RULE14: Reset clears every cell and restarts distributor at phase 0.
`timescale 1ns/1ps
`default_nettype none
module fpcs_core (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  load_one,
    input  wire logic                  inhibit,
    output fpcs_pkg::fpcs_pulses_s     pulses,
    output logic [1:0]                 phase,
    output logic [3:0]                 cell_bits,
    output logic                       transfer_pulse_phase_one,
    output logic                       transfer_pulse_phase_three,
    output logic                       read_pulse_phase_one,
    output logic                       read_pulse_phase_three
);
    // ==========================================================
    // Pulse distributor
    // ==========================================================
    fpcs_pkg::fpcs_phase_e              phase_r;
    fpcs_pkg::fpcs_phase_e              phase_nxt;
    logic [fpcs_pkg::CNT_W-1:0]         cnt_r;
    logic [fpcs_pkg::CNT_W-1:0]         cnt_nxt;
    logic                               phase_end;
    logic [3:0]                         cur_onehot;
    logic [3:0]                         prev_onehot;
    logic [3:0]                         tp;
    logic [3:0]                         rp;
    logic [3:0]                         rp_first;
    logic                               load_one_s1_r;
    logic                               load_one_s2_r;
    logic                               inhibit_s1_r;
    logic                               inhibit_s2_r;

    assign phase_end = (cnt_r == fpcs_pkg::CNT_LAST);
    assign cnt_nxt   = phase_end ? fpcs_pkg::CNT_ZERO : cnt_r + 8'h01;

    always_comb begin
        case (phase_r)
            fpcs_pkg::FPCS_PH0: phase_nxt = fpcs_pkg::FPCS_PH1;
            fpcs_pkg::FPCS_PH1: phase_nxt = fpcs_pkg::FPCS_PH2;
            fpcs_pkg::FPCS_PH2: phase_nxt = fpcs_pkg::FPCS_PH3;
            fpcs_pkg::FPCS_PH3: phase_nxt = fpcs_pkg::FPCS_PH0; // [RULE3]
            default:            phase_nxt = fpcs_pkg::FPCS_PH0;
        endcase
    end

    // Slot counter: one slot is one transfer width
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= fpcs_pkg::CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Phase moves only at slot end, so every slot has the same length
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= fpcs_pkg::FPCS_PH0; // [RULE14]
        end else begin
            phase_r <= phase_end ? phase_nxt : phase_r;
        end
    end

    // Each phase slot is one transfer width; read covers its own slot and the next
    assign cur_onehot  = 4'h1 << phase_r;
    assign prev_onehot = {cur_onehot[0], cur_onehot[3:1]};
    // Only one slot active, so transfers never coincide [RULE4] [RULE6] [RULE7]
    assign tp          = cur_onehot;
    // Read of phase k spans slot k and k+1: 1 us overlap with next read [RULE5] [RULE6]
    assign rp          = cur_onehot | prev_onehot;
    // First cycle of a read empties the cell; later cycles only hold the output
    assign rp_first    = (cnt_r == fpcs_pkg::CNT_ZERO) ? cur_onehot : 4'h0;

    // ==========================================================
    // Outputs
    // ==========================================================
    assign pulses.transfer            = tp; // [RULE3]
    assign pulses.read                = rp;
    assign phase                      = phase_r;
    assign transfer_pulse_phase_one   = tp[1];
    assign transfer_pulse_phase_three = tp[3];
    assign read_pulse_phase_one       = rp[1];
    assign read_pulse_phase_three     = rp[3];

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Only the second stage is read, the first may be metastable
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            load_one_s1_r <= 1'b0;
            load_one_s2_r <= 1'b0;
        end else begin
            load_one_s1_r <= load_one;
            load_one_s2_r <= load_one_s1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            inhibit_s1_r <= 1'b0;
            inhibit_s2_r <= 1'b0;
        end else begin
            inhibit_s1_r <= inhibit;
            inhibit_s2_r <= inhibit_s1_r;
        end
    end

    // ==========================================================
    // Cell ring: cell k is read at phase k, feeds cell k+1
    // ==========================================================
    logic [3:0] out_bits;
    logic [3:0] stored;
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic       ring_set_0;
    logic       load_set_0;

    // Set only at the sink's n-1 from the source read with transfer coincident [RULE8] [RULE11]
    // Sink was emptied by its own read three phases earlier, so it holds 0 [RULE10] [RULE12]
    assign set_v[1] = out_bits[0] & tp[0];
    assign set_v[2] = out_bits[1] & tp[1];
    assign set_v[3] = out_bits[2] & tp[2];
    // Ring closes through a real read of cell 3, so the source is emptied [RULE8]
    assign ring_set_0 = out_bits[3] & tp[3];
    // External load lands at n-2, ahead of the inhibit clear [RULE11] [RULE13]
    assign load_set_0 = load_one_s2_r & tp[2];
    assign set_v[0]   = ring_set_0 | load_set_0;
    // Clear wins over a same-cycle set, so inhibit also blocks the ring bit [RULE13]
    assign clr_v[0]   = tp[3] & inhibit_s2_r;
    assign clr_v[3:1] = 3'h0;

    // ==========================================================
    // Cell 0: read at phase 0
    // ==========================================================
    fpcs_cell fpcs_cell_0_inst (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_in     (set_v[0]),
        .clear_in   (clr_v[0]),
        .read_in    (rp[0]),
        .read_first (rp_first[0]),
        .bit_out    (out_bits[0]),
        .stored     (stored[0])
    );

    // ==========================================================
    // Cell 1: read at phase 1
    // ==========================================================
    fpcs_cell fpcs_cell_1_inst (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_in     (set_v[1]),
        .clear_in   (clr_v[1]),
        .read_in    (rp[1]),
        .read_first (rp_first[1]),
        .bit_out    (out_bits[1]),
        .stored     (stored[1])
    );

    // ==========================================================
    // Cell 2: read at phase 2
    // ==========================================================
    fpcs_cell fpcs_cell_2_inst (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_in     (set_v[2]),
        .clear_in   (clr_v[2]),
        .read_in    (rp[2]),
        .read_first (rp_first[2]),
        .bit_out    (out_bits[2]),
        .stored     (stored[2])
    );

    // ==========================================================
    // Cell 3: read at phase 3, feeds cell 0
    // ==========================================================
    fpcs_cell fpcs_cell_3_inst (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_in     (set_v[3]),
        .clear_in   (clr_v[3]),
        .read_in    (rp[3]),
        .read_first (rp_first[3]),
        .bit_out    (out_bits[3]),
        .stored     (stored[3])
    );

    // Stored bits come straight from the cell flip-flops
    assign cell_bits = stored;
endmodule
`default_nettype wire

// [test/fpcs_core_props.sv]
// Checker for the four-phase core switch fabric
`timescale 1ns/1ps
`default_nettype none
module fpcs_core_props (
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic                   load_one,
    input wire logic                   inhibit,
    input wire fpcs_pkg::fpcs_pulses_s pulses,
    input wire logic [1:0]             phase,
    input wire logic [3:0]             cell_bits,
    input wire logic                   transfer_pulse_phase_one,
    input wire logic                   transfer_pulse_phase_three,
    input wire logic                   read_pulse_phase_one,
    input wire logic                   read_pulse_phase_three
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ==========
    // Pulses
    a_transfer_one_hot: assert property ($onehot(pulses.transfer))
        else $error("transfer not one-hot");
    a_phase_selects: assert property (pulses.transfer == 4'h1 << phase)
        else $error("transfer bit off phase");
    a_read_overlap: assert property (
        pulses.read == (pulses.transfer | {pulses.transfer[0], pulses.transfer[3:1]}))
        else $error("read pair wrong");
    a_slot_length: assert property ($changed(phase) |=>
        $stable(phase)[*8] ##1 $stable(phase) ##1 $changed(phase))
        else $error("slot not 10 cycles");
    a_phase_order: assert property ($changed(phase) |-> phase == $past(phase) + 2'h1)
        else $error("phase skipped");
    a_read_tail: assert property ($fell(transfer_pulse_phase_one) |->
        read_pulse_phase_one ##10 !read_pulse_phase_one)
        else $error("read tail wrong");
    a_alias_bits: assert property ({transfer_pulse_phase_one, transfer_pulse_phase_three,
        read_pulse_phase_one, read_pulse_phase_three} == {pulses.transfer[1],
        pulses.transfer[3], pulses.read[1], pulses.read[3]})
        else $error("named pulse differs");
    // ==========
    // Cells; a set lands two cycles into its slot, so allow that slack
    a_read_clears: assert property ($stable(phase) && phase == $past(phase, 2) |->
        !cell_bits[phase])
        else $error("read cell not empty");
    a_cells_hold: assert property ($stable(phase) && phase == $past(phase, 3) |->
        $stable(cell_bits[3:1]))
        else $error("cell moved mid-slot");
    c_full_cycle: cover property (phase == 2'h3 ##1 phase == 2'h0);
    c_bit_moves: cover property ($rose(cell_bits[3]));
    c_inhibit: cover property (load_one && inhibit);
endmodule
bind fpcs_core fpcs_core_props fpcs_core_props_inst (.sys_clk(sys_clk), .resetn(resetn),
    .load_one(load_one), .inhibit(inhibit), .pulses(pulses), .phase(phase), .cell_bits(cell_bits),
    .transfer_pulse_phase_one(transfer_pulse_phase_one), .transfer_pulse_phase_three(transfer_pulse_phase_three),
    .read_pulse_phase_one(read_pulse_phase_one), .read_pulse_phase_three(read_pulse_phase_three));
`default_nettype wire

// [test/tb_fpcs_core.sv]
// Self-checking testbench for the four-phase core switch fabric
`timescale 1ns/1ps
`default_nettype none
module tb_fpcs_core;
    logic                   sys_clk = 1'b0;
    logic                   resetn = 1'b0;
    logic                   load_one = 1'b0;
    logic                   inhibit = 1'b0;
    fpcs_pkg::fpcs_pulses_s pulses;
    logic [1:0]             phase;
    logic [3:0]             cell_bits;
    int                     n_errors = 0;
    int                     checked = 0;
    fpcs_core fpcs_core_inst (.sys_clk(sys_clk), .resetn(resetn), .load_one(load_one), .inhibit(inhibit),
        .pulses(pulses), .phase(phase), .cell_bits(cell_bits), .transfer_pulse_phase_one(),
        .transfer_pulse_phase_three(), .read_pulse_phase_one(), .read_pulse_phase_three());
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    task automatic check(input logic ok, input string msg);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Bounded wait, since a stuck distributor would hang here
    task automatic wait_phase(input logic [1:0] p);
        for (int i = 0; phase !== p; i++) begin
            if (i > 50) begin
                n_errors++;
                wrap_up();
            end
            tick(1);
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_reset(input int n);
        resetn = 1'b0;
        tick(n);
        check(phase === 2'h0 && cell_bits === 4'h0, "reset state");
        check(pulses === {4'h1, 4'h9}, "reset pulses");
        resetn = 1'b1;
    endtask
    task automatic t_walk();
        logic [1:0] p;
        wait_phase(2'h1);
        for (int j = 0; j < 40; j++) begin
            p = 2'(1 + j / 10);
            check(phase === p && pulses.transfer === 4'h1 << p, "transfer phase");
            check(pulses.read === ((4'h1 << p) | (4'h1 << 2'(p - 2'h1))), "read overlap");
            tick(1);
        end
    endtask
    task automatic t_load();
        logic [3:0] seen;
        seen = 4'h0;
        load_one = 1'b1;
        wait_phase(2'h2);
        wait_phase(2'h3);
        load_one = 1'b0;
        for (int j = 0; j < 60; j++) begin
            check($countones(cell_bits) <= 1, "bit duplicated");
            seen = seen | cell_bits;
            tick(1);
        end
        check(seen[3:1] === 3'h7, "bit did not travel");
    endtask
    task automatic t_inhibit();
        load_one = 1'b1;
        inhibit = 1'b1;
        for (int j = 0; j < 60; j++) begin
            check(cell_bits[3:1] === 3'h0, "inhibited bit passed");
            tick(1);
        end
        load_one = 1'b0;
        inhibit = 1'b0;
    endtask
    initial begin
        tick(1);
        t_reset(6);
        t_walk();
        t_load();
        t_reset(2);
        t_inhibit();
        wrap_up();
    end
endmodule
`default_nettype wire
